/* rtl/dual_timer_counter_core.sv */
// two independent 16-bit timer/counters with register port and masked interrupt
// Function
// - two 16-bit timer/counter channels, each with its own source and gating select; double speed is common
// - timer use counts a programmed interval, then requests an interrupt
// - counter use counts falling edges on the channel's event pin
// - counter use requests an interrupt after a preset number of events
// - run bit set lets each source pulse bump the low byte; clear stops counting
// - low byte overflow increments the high byte, forming one 16-bit count
// - high byte overflow sets the channel overflow flag in the control register
// - setting the run bit leaves both count bytes unchanged
// - both count bytes readable any time without disturbing counting
// - source select zero picks divided peripheral clock, one picks event pin
// - timer source advances once per peripheral cycle of six peripheral clocks
// - timer rate is oscillator/12 standard, oscillator/6 double speed
// - event pin sampled per peripheral cycle; high then low counts one
// - gating off: run bit alone enables; gating on: gate pin also required
// - rollover from all ones to zero sets the flag, which requests interrupt
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
module dual_timer_counter_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tmr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [tmr_pkg::NUM_CH-1:0] event_pin,
  input wire logic [tmr_pkg::NUM_CH-1:0] gate_interrupt_pin,
  input wire logic [tmr_pkg::NUM_CH-1:0] irq_ack,
  output logic irq
);
  import tmr_pkg::*;

  // byte address of a channel's low or high count byte
  function automatic logic [ADDR_W-1:0] cnt_addr(input int ch, input logic hi);
    cnt_addr = (ch == 0) ? (hi ? REG_CNT0_HI : REG_CNT0_LO) : (hi ? REG_CNT1_HI : REG_CNT1_LO);
  endfunction

  logic rst_meta_q, rst_sync_q;
  logic rst_n;

  logic [3:0] psc_q, psc_d;
  logic tick_q, tick_d;
  logic [3:0] tick_div;

  logic [NUM_CH-1:0] run_q, run_d;
  logic [NUM_CH-1:0] overflow_flag_q, overflow_flag_d;
  logic [7:0] mode_q, mode_d;
  logic [NUM_CH-1:0] mask_q, mask_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic irq_q, irq_d;

  logic [NUM_CH-1:0] wr_lo, wr_hi, ovf;
  logic [CNT_W-1:0] cnt [NUM_CH];
  logic ctrl_wr, mode_wr;

  // reset enters asynchronously but is released on the clock through two stages
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // peripheral-cycle strobe; core_clk stands for the oscillator
  always_comb begin
    tick_div = mode_q[MODE_DOUBLE] ? TICK_DIV_X2 : TICK_DIV_STD;
    // >= lets a rate change mid-cycle finish the current cycle early rather than wrap
    if (psc_q >= tick_div - 4'h1) begin
      psc_d = 4'h0;
      tick_d = 1'b1;
    end else begin
      psc_d = psc_q + 4'h1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      psc_q <= psc_d;
      tick_q <= tick_d;
    end
  end

  // register writes, flags and read data
  always_comb begin
    ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
    mode_wr = reg_wr && (reg_addr == REG_MODE);
    run_d = run_q;
    mode_d = mode_q;
    mask_d = mask_q;
    if (ctrl_wr) begin
      run_d = reg_wdata[CTRL_RUN0 +: NUM_CH];
    end
    if (mode_wr) begin
      mode_d = reg_wdata;
    end
    if (reg_wr && (reg_addr == REG_MASK)) begin
      mask_d = reg_wdata[NUM_CH-1:0];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      wr_lo[i] = reg_wr && (reg_addr == cnt_addr(i, 1'b0));
      wr_hi[i] = reg_wr && (reg_addr == cnt_addr(i, 1'b1));
      overflow_flag_d[i] = overflow_flag_q[i];
      if ((ctrl_wr && reg_wdata[CTRL_FLAG0 + i]) || irq_ack[i]) begin
        overflow_flag_d[i] = 1'b0;
      end
      // an overflow in the clearing cycle is kept
      if (ovf[i]) begin
        overflow_flag_d[i] = 1'b1;
      end
    end
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: begin
          rdata_d = 8'h00;
          rdata_d[CTRL_RUN0 +: NUM_CH] = run_q;
          rdata_d[CTRL_FLAG0 +: NUM_CH] = overflow_flag_q;
        end
        REG_MODE: begin
          rdata_d = mode_q;
        end
        REG_CNT0_LO: begin
          rdata_d = cnt[0][7:0];
        end
        REG_CNT0_HI: begin
          rdata_d = cnt[0][15:8];
        end
        REG_CNT1_LO: begin
          rdata_d = cnt[1][7:0];
        end
        REG_CNT1_HI: begin
          rdata_d = cnt[1][15:8];
        end
        REG_MASK: begin
          rdata_d = {6'h00, mask_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
    // interrupt follows the flags as they will stand after this edge
    irq_d = |(overflow_flag_d & mask_d);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= CTRL_RST[CTRL_RUN0 +: NUM_CH];
      overflow_flag_q <= CTRL_RST[CTRL_FLAG0 +: NUM_CH];
      mode_q <= MODE_RST;
      mask_q <= MASK_RST;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      run_q <= run_d;
      overflow_flag_q <= overflow_flag_d;
      mode_q <= mode_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;

  // channels share nothing but the peripheral-cycle strobe and the register write data
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    timer_channel u_ch (
      .clk(core_clk),
      .rst_n(rst_n),
      .tick(tick_q),
      .run_control_bit(run_q[g]),
      .src_sel(mode_q[MODE_SRC_SEL0 + g * MODE_CH_STRIDE]),
      .gating_enable_bit(mode_q[MODE_GATING_ENABLE_BIT + g * MODE_CH_STRIDE]),
      .gate_lvl(gate_interrupt_pin[g]),
      .event_pin(event_pin[g]),
      .wr_lo(wr_lo[g]),
      .wr_hi(wr_hi[g]),
      .wr_data(reg_wdata),
      .count(cnt[g]),
      .ovf(ovf[g])
    );
  end

  tick_x2_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n || mode_wr)
    (tick_q && mode_q[MODE_DOUBLE]) |=> !tick_q [*5] ##1 tick_q)
    else $error("double speed tick spacing is not six clocks");
  tick_std_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n || mode_wr)
    (tick_q && !mode_q[MODE_DOUBLE]) |=> !tick_q [*8] ##1 !tick_q [*3] ##1 tick_q)
    else $error("standard tick spacing is not twelve clocks");
  ovf_sets_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ovf[0] |=> overflow_flag_q[0] && (irq == (mask_q[0] | (overflow_flag_q[1] & mask_q[1]))))
    else $error("overflow did not set flag and interrupt");
  flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overflow_flag_q[1] && !irq_ack[1] && !(ctrl_wr && reg_wdata[CTRL_FLAG0 + 1])) |=> overflow_flag_q[1])
    else $error("overflow flag dropped without clear");
  irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == |(overflow_flag_q & mask_q))
    else $error("interrupt differs from masked flags");
  count_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_CNT1_HI) |=> reg_rdata == $past(cnt[1][15:8]))
    else $error("count read returned wrong byte");

  // register port: writes land next edge, reads stand one cycle
  run_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_wr |=> run_q == $past(reg_wdata[CTRL_RUN0 +: NUM_CH]))
    else $error("run bits not taken from control write");
  run_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_wr |=> $stable(run_q))
    else $error("run bits changed without control write");
  mode_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_wr |=> mode_q == $past(reg_wdata))
    else $error("mode not taken from mode write");
  mode_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !mode_wr |=> $stable(mode_q))
    else $error("mode changed without mode write");
  mask_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == REG_MASK) |=> mask_q == $past(reg_wdata[NUM_CH-1:0]))
    else $error("mask not taken from mask write");
  mask_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == REG_MASK) |=> $stable(mask_q))
    else $error("mask changed without mask write");
  read_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  read_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_CTRL) |=> reg_rdata[CTRL_RUN0 +: NUM_CH] == $past(run_q))
    else $error("control read returned wrong run bits");
  read_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_CTRL) |=> reg_rdata[CTRL_FLAG0 +: NUM_CH] == $past(overflow_flag_q))
    else $error("control read returned wrong flags");
  read_cnt0_lo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_CNT0_LO) |=> reg_rdata == $past(cnt[0][7:0]))
    else $error("channel 0 low byte read wrong");
  read_cnt0_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_CNT0_HI) |=> reg_rdata == $past(cnt[0][15:8]))
    else $error("channel 0 high byte read wrong");
  read_cnt1_lo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_CNT1_LO) |=> reg_rdata == $past(cnt[1][7:0]))
    else $error("channel 1 low byte read wrong");
  read_no_disturb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && !tick_q) |=> $stable(cnt[0]) && $stable(cnt[1]))
    else $error("count read disturbed a count");
  preset_lo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_lo[0] |=> cnt[0][7:0] == $past(reg_wdata))
    else $error("low byte preset did not land");
  preset_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hi[1] |=> cnt[1][15:8] == $past(reg_wdata))
    else $error("high byte preset did not land");

  // prescaler and counting cadence
  tick_phase_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick_q |-> psc_q == 4'h0)
    else $error("tick away from prescaler wrap");
  psc_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    psc_q < TICK_DIV_STD)
    else $error("prescaler ran past its longest cycle");
  ovf_on_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ovf != '0) |-> tick_q)
    else $error("overflow outside a peripheral cycle");
  quiet_between_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!tick_q && !wr_lo[1] && !wr_hi[1]) |=> $stable(cnt[1]))
    else $error("count moved between peripheral cycles");

  // flags and interrupt
  ovf1_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ovf[1] |=> overflow_flag_q[1])
    else $error("channel 1 overflow did not set flag");
  flag0_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overflow_flag_q[0] && !irq_ack[0] && !(ctrl_wr && reg_wdata[CTRL_FLAG0])) |=> overflow_flag_q[0])
    else $error("channel 0 flag dropped without clear");
  ack_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (irq_ack[0] && !ovf[0]) |=> !overflow_flag_q[0])
    else $error("acknowledge did not clear flag");
  wr_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctrl_wr && reg_wdata[CTRL_FLAG0 + 1] && !ovf[1]) |=> !overflow_flag_q[1])
    else $error("write one did not clear flag");
  no_false_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!overflow_flag_q[0] && !ovf[0]) |=> !overflow_flag_q[0])
    else $error("flag set without overflow");
  masked_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mask_q == '0) |-> !irq)
    else $error("interrupt raised with all sources masked");

  flag_irq_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    ovf[0] ##1 irq);
  set_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    ovf[1] && irq_ack[1]);
  mode_switch_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    mode_wr && reg_wdata[MODE_DOUBLE] && !mode_q[MODE_DOUBLE]);
endmodule

/* rtl/tmr_pkg.sv */
// constants shared by the dual timer/counter core and its channels
package tmr_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 2;

  // register offsets
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_CNT0_LO = 3'h2;
  localparam logic [2:0] REG_CNT0_HI = 3'h3;
  localparam logic [2:0] REG_CNT1_LO = 3'h4;
  localparam logic [2:0] REG_CNT1_HI = 3'h5;
  localparam logic [2:0] REG_MASK = 3'h6;

  // timer_control_reg fields: run bits low, overflow flags (write one to clear) high
  localparam int CTRL_RUN0 = 0;
  localparam int CTRL_FLAG0 = 4;
  // mode register fields, channel 1 sits MODE_CH_STRIDE bits above channel 0
  localparam int MODE_SRC_SEL0 = 0;
  localparam int MODE_GATING_ENABLE_BIT = 1;
  localparam int MODE_CH_STRIDE = 4;
  localparam int MODE_DOUBLE = 7;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [7:0] CNT_RST = 8'h00;

  // peripheral cycle = 6 peripheral clocks; peripheral clock = osc/2 standard, osc/1 double speed
  localparam int PER_CLKS_PER_CYCLE = 6;
  localparam int OSC_PER_PER_STD = 2;
  localparam int OSC_PER_PER_X2 = 1;
  localparam logic [3:0] TICK_DIV_STD = 4'(PER_CLKS_PER_CYCLE * OSC_PER_PER_STD);
  localparam logic [3:0] TICK_DIV_X2 = 4'(PER_CLKS_PER_CYCLE * OSC_PER_PER_X2);
endpackage

/* rtl/timer_channel.sv */
// one 16-bit timer/counter channel built from two cascaded count bytes
`timescale 1ns/100ps
module timer_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run_control_bit,
  input wire logic src_sel,
  input wire logic gating_enable_bit,
  input wire logic gate_lvl,
  input wire logic event_pin,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [tmr_pkg::DATA_W-1:0] wr_data,
  output logic [tmr_pkg::CNT_W-1:0] count,
  output logic ovf
);
  import tmr_pkg::*;

  logic [7:0] count_low_byte_q, count_low_byte_d;
  logic [7:0] count_high_byte_q, count_high_byte_d;
  logic samp_q, samp_d;
  logic fall;
  logic cnt_en;
  logic inc;

  always_comb begin
    // pin is sampled once per peripheral cycle whether or not the channel runs
    samp_d = tick ? event_pin : samp_q;
    fall = samp_q & ~event_pin;
    cnt_en = run_control_bit & (~gating_enable_bit | gate_lvl);
    inc = tick & cnt_en & (src_sel ? fall : 1'b1);
    count_low_byte_d = count_low_byte_q;
    count_high_byte_d = count_high_byte_q;
    ovf = 1'b0;
    if (inc) begin
      count_low_byte_d = count_low_byte_q + 8'h01;
      if (count_low_byte_q == 8'hFF) begin
        count_high_byte_d = count_high_byte_q + 8'h01;
        ovf = (count_high_byte_q == 8'hFF);
      end
    end
    // a preset overrides the same-cycle increment or carry of the byte it writes only; software must stop the channel first
    if (wr_lo) begin
      count_low_byte_d = wr_data;
    end
    if (wr_hi) begin
      count_high_byte_d = wr_data;
    end
  end

  // run-control changes never touch the count bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte_q <= CNT_RST;
      count_high_byte_q <= CNT_RST;
      samp_q <= 1'b0;
    end else begin
      count_low_byte_q <= count_low_byte_d;
      count_high_byte_q <= count_high_byte_d;
      samp_q <= samp_d;
    end
  end

  assign count = {count_high_byte_q, count_low_byte_q};

  hold_when_stopped_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!run_control_bit && !wr_lo && !wr_hi) |=> $stable(count))
    else $error("count moved while stopped");
  timer_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && cnt_en && !src_sel && !wr_lo && !wr_hi) |=> count == $past(count) + 16'h0001)
    else $error("timer tick did not advance count by one");
  falling_edge_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && cnt_en && src_sel && samp_q && !event_pin && !wr_lo && !wr_hi) |=> count == $past(count) + 16'h0001)
    else $error("falling edge on event pin not counted");
  no_edge_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (src_sel && !(tick && samp_q && !event_pin) && !wr_lo && !wr_hi) |=> $stable(count))
    else $error("counter moved without a falling edge");
  gate_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
    (gating_enable_bit && !gate_lvl && !wr_lo && !wr_hi) |=> $stable(count))
    else $error("count moved while gate pin low");
  rollover_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovf == (inc && count == 16'hFFFF))
    else $error("overflow pulse not tied to rollover");

  counter_edge_c: cover property (@(posedge clk) disable iff (!rst_n)
    tick && cnt_en && src_sel && fall);
  gated_stop_c: cover property (@(posedge clk) disable iff (!rst_n)
    run_control_bit && gating_enable_bit && !gate_lvl && tick);
endmodule

/* dv/ext_pins.sv */
// partner model: event pins and gate pins in front of both channels
`timescale 1ns/100ps
module ext_pins (
  input wire logic core_clk,
  output logic [1:0] event_pin,
  output logic [1:0] gate_interrupt_pin
);
  initial begin
    event_pin = 2'h3;
    gate_interrupt_pin = 2'h0;
  end
  // each level is held past one standard peripheral cycle so a tick always samples it
  task automatic pulse(input int ch);
    repeat (13) @(posedge core_clk);
    event_pin[ch] <= 1'b0;
    repeat (13) @(posedge core_clk);
    event_pin[ch] <= 1'b1;
  endtask
  task automatic gate(input int ch, input logic v);
    @(posedge core_clk);
    gate_interrupt_pin[ch] <= v;
  endtask
endmodule

/* dv/dual_timer_counter_core_tb.sv */
// self-checking bench: reference model of both channels compared at every cycle
`timescale 1ns/100ps
module dual_timer_counter_core_tb;
  import tmr_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, irq, r1, r2, tick, tw, f;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mode, m_rd;
  logic [1:0] event_pin, gate_interrupt_pin, irq_ack, run, flg, msk, smp;
  logic [3:0] pre;
  logic [15:0] cnt [2];
  logic [15:0] seed = 16'hB46E;
  int n_mismatch = 0;
  int samples_checked = 0;

  dual_timer_counter_core i_dual_timer_counter_core (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_pin(event_pin),
    .gate_interrupt_pin(gate_interrupt_pin), .irq_ack(irq_ack), .irq(irq));
  ext_pins i_ext_pins (.core_clk(core_clk), .event_pin(event_pin), .gate_interrupt_pin(gate_interrupt_pin));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] rd_val(input logic [2:0] a);
    case (a)
      REG_CTRL: return {2'h0, flg, 2'h0, run};
      REG_MODE: return mode;
      REG_CNT0_LO: return cnt[0][7:0];
      REG_CNT0_HI: return cnt[0][15:8];
      REG_CNT1_LO: return cnt[1][7:0];
      REG_CNT1_HI: return cnt[1][15:8];
      REG_MASK: return {6'h00, msk};
      default: return 8'h00;
    endcase
  endfunction

  always @(posedge core_clk or negedge nrst)
    if (!nrst) {r1, r2} <= 2'h0;
    else {r1, r2} <= {1'b1, r1};
  // the peripheral-cycle strobe is registered, so counting lands one edge after the prescaler wraps
  assign tw = pre >= (mode[MODE_DOUBLE] ? TICK_DIV_X2 - 4'h1 : TICK_DIV_STD - 4'h1);
  always @(posedge core_clk or negedge r2) begin
    if (!r2) begin
      {pre, tick, run, flg, msk, smp, mode, m_rd} <= '0;
      cnt[0] <= 16'h0000;
      cnt[1] <= 16'h0000;
    end else begin
      pre <= tw ? 4'h0 : pre + 4'h1;
      tick <= tw;
      m_rd <= reg_rd ? rd_val(reg_addr) : 8'h00;
      for (int c = 0; c < 2; c++) begin
        f = flg[c] & ~irq_ack[c] & ~(reg_wr && reg_addr == REG_CTRL && reg_wdata[4 + c]);
        if (tick) smp[c] <= event_pin[c];
        if (tick && run[c] && (!mode[4*c+1] || gate_interrupt_pin[c]) &&
            (!mode[4*c] || (smp[c] && !event_pin[c]))) begin
          f = f | (cnt[c] == 16'hFFFF);
          cnt[c] <= cnt[c] + 16'h0001;
        end
        flg[c] <= f;
      end
      if (reg_wr) begin
        case (reg_addr)
          REG_CTRL: run <= reg_wdata[1:0];
          REG_MODE: mode <= reg_wdata;
          REG_CNT0_LO: cnt[0][7:0] <= reg_wdata;
          REG_CNT0_HI: cnt[0][15:8] <= reg_wdata;
          REG_CNT1_LO: cnt[1][7:0] <= reg_wdata;
          REG_CNT1_HI: cnt[1][15:8] <= reg_wdata;
          REG_MASK: msk <= reg_wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_irq(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch irq expected %b seen %b", e, g);
    end
  endtask
  always @(posedge core_clk) begin
    #1;
    if (r2 === 1'b1) begin
      chk("reg_rdata", m_rd, reg_rdata);
      chk_irq(|(flg & msk), irq);
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic rdall();
    for (int a = 0; a < 8; a++) rd(3'(a));
  endtask
  // the channel is always stopped first; presetting a running count is undefined
  task automatic start_ch(input int c, input logic [7:0] md, input logic [7:0] lo_or);
    wr(REG_CTRL, 8'h00);
    wr(REG_MODE, md);
    seed = lfsr(seed);
    wr(3'(REG_CNT0_LO + 2*c), seed[7:0] | lo_or);
    wr(3'(REG_CNT0_HI + 2*c), 8'hFF);
    wr(REG_CTRL, 8'(1 << c));
  endtask
  task automatic poll(input int c, input int n);
    repeat (n) begin
      rd(3'(REG_CNT0_LO + 2*c));
      rd(3'(REG_CNT0_HI + 2*c));
      repeat (4) @(posedge core_clk);
    end
  endtask
  task automatic fin(input string nm);
    rdall();
    $display("test %s done", nm);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, irq_ack} = '0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdall();
    wr(REG_MODE, 8'h5A);
    wr(3'h7, 8'hFF);
    wr(REG_MASK, 8'h02);
    fin("registers");
    start_ch(0, 8'h00, 8'hC0);
    poll(0, 110);
    wr(REG_MASK, 8'h03);
    wr(REG_CTRL, 8'h00);
    poll(0, 4);
    wr(REG_CTRL, 8'h01);
    poll(0, 6);
    wr(REG_CTRL, 8'h10);
    fin("timer standard");
    start_ch(1, 8'h80, 8'hC0);
    poll(1, 60);
    fin("timer double speed");
    start_ch(0, 8'h01, 8'hFC);
    fork
      repeat (6) i_ext_pins.pulse(0);
      poll(0, 40);
    join
    @(posedge core_clk);
    irq_ack <= 2'h1;
    @(posedge core_clk);
    irq_ack <= 2'h0;
    fin("event counter");
    wr(REG_CTRL, 8'h20);
    start_ch(1, 8'h20, 8'hC0);
    poll(1, 20);
    i_ext_pins.gate(1, 1'b1);
    poll(1, 110);
    wr(REG_CTRL, 8'h30);
    fin("gated timer");
    // channel 1 as a gated event counter at double speed, gate pin still high
    start_ch(1, 8'hB0, 8'hFC);
    fork
      repeat (6) i_ext_pins.pulse(1);
      poll(1, 40);
    join
    wr(REG_CTRL, 8'h30);
    fin("gated counter double speed");
    summarize();
  end
endmodule
